// *** core/scc_pkg.sv ***
// Package for the system clock output control block: channel map,
// register offsets, reset values and the carrier types.
// Assumes a single 50 MHz bus clock and clock sources sampled on it.
package scc_pkg;

  // Bus clock, used only for documentation of the sampling rate
  localparam int          CLK_MHZ      = 50;

  // Gated output channels, one enable bit each
  localparam int          NCH          = 22;
  localparam int          CH_CPU0      = 0;
  localparam int          CH_PCI0      = 2;
  localparam int          CH_PCIF      = 8;
  localparam int          CH_REF0      = 9;
  localparam int          CH_FIXA      = 12;
  localparam int          CH_FIXB      = 13;
  localparam int          CH_MEM0      = 14;
  localparam int          CH_MEMA      = 20;
  localparam int          CH_MEMB      = 21;
  localparam int          NCPU         = 2;
  localparam int          NPCI         = 6;
  localparam int          NREF         = 3;
  localparam int          NMEM         = 6;

  // Register byte offsets within the slave window
  localparam logic [7:0]  OFF_ENABLE   = 8'h00;
  localparam logic [7:0]  OFF_FIXSEL   = 8'h04;
  localparam logic [7:0]  OFF_STATUS   = 8'h08;
  localparam int          ADDR_LSB_W   = 8;

  // Reset values: every output on, both fixed outputs at the fast rate
  localparam logic [21:0] ENABLE_RST   = 22'h3fffff;
  localparam logic [1:0]  FIXSEL_RST   = 2'h3;
  localparam int          FIXSEL_W     = 2;
  localparam int          FIXSEL_A     = 0;
  localparam int          FIXSEL_B     = 1;

  // Mode pin value that turns the shared pins into clock outputs
  localparam logic        MODE_MEMORY  = 1'b1;

  // AHB-Lite encodings
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'b0;

  // Clock source levels coming from the oscillator and PLL stages
  typedef struct packed {
    logic cpu_66;   // Processor rate source, low speed
    logic cpu_100;  // Processor rate source, high speed
    logic pci;      // 33.3 MHz bus rate source
    logic fix_48;   // 48 MHz source
    logic fix_24;   // 24 MHz source
  } scc_src_s;

  // Status word, low bits of the status register
  typedef struct packed {
    logic vco_run;     // PLL stage running
    logic osc_run;     // Crystal oscillator running
    logic cpu_stop_n;  // Effective processor stop level
    logic pci_stop_n;  // Effective bus stop level
    logic speed;       // Processor speed select pin
    logic mode;        // Mode pin
  } scc_status_s;

  localparam int          STATUS_W     = 6;

endpackage

// *** core/scc_clk_gate.sv ***
// One glitch-free output gate: a clock source level in, a gated level out.
// Assumes the source level is synchronous to hclk and slower than hclk/2.
module scc_clk_gate (
  input  wire logic hclk,     // Bus clock
  input  wire logic hresetn,  // Async reset, active low
  input  wire logic src,      // Source clock level
  input  wire logic run,      // Request to pass the source
  output logic      clk_out   // Gated clock, registered
);

  logic run_r;

  // Run state changes only while the source is low, so no runt pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_r <= 1'b0;
    end else if (!src) begin
      run_r <= run;
    end
  end

  // Output follows the source only under a settled run state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_out <= 1'b0;
    end else begin
      clk_out <= src & run_r;
    end
  end

endmodule

// *** core/scc_top.sv ***
// Output control of the system clock generator with an AHB-Lite register port.
// Assumes source clock levels arrive synchronous to hclk from the PLL stages,
// and a single AHB-Lite master with this slave as the only one on the bus.
//
// The placing of the registers and register access over AHB-Lite were left to the implementer.

module scc_top (
  input  wire logic                 hclk,                      // Bus clock, 50 MHz
  input  wire logic                 hresetn,                   // Async reset, active low
  input  wire logic                 hsel,                      // Slave select
  input  wire logic [31:0]          haddr,                     // Byte address
  input  wire logic [1:0]           htrans,                    // Transfer type
  input  wire logic                 hwrite,                    // Write when high
  input  wire logic [2:0]           hsize,                     // Transfer size
  input  wire logic [31:0]          hwdata,                    // Write data
  input  wire logic                 hready,                    // Bus ready in
  output logic                      hreadyout,                 // Slave ready out
  output logic [31:0]               hrdata,                    // Read data, registered
  output logic                      hresp,                     // Always OKAY
  input  wire logic                 cpu_speed_select,          // 1 fast, 0 slow rate
  input  wire logic                 power_down_n,              // Power-down, active low
  input  wire logic                 mode_select,               // Shared pin function
  input  wire logic                 crystal_input,             // Crystal clock level
  input  wire logic                 buf_in,                    // Memory buffer input
  input  wire scc_pkg::scc_src_s    pll_src,                   // PLL source levels
  input  wire logic                 memory_clock_extra_a_i,    // Shared pin A level
  output logic                      memory_clock_extra_a_o,    // Shared pin A drive
  output logic                      memory_clock_extra_a_oe,   // Shared pin A enable
  input  wire logic                 memory_clock_extra_b_i,    // Shared pin B level
  output logic                      memory_clock_extra_b_o,    // Shared pin B drive
  output logic                      memory_clock_extra_b_oe,   // Shared pin B enable
  output logic [1:0]                cpu_clock_out,             // Processor clocks
  output logic [5:0]                pci_clock_out,             // Stoppable bus clocks
  output logic                      pci_clock_free_running,    // Free bus clock
  output logic [2:0]                ref_clock_out,             // Reference clocks
  output logic                      fixed_clock_out_a,         // 48/24 MHz output A
  output logic                      fixed_clock_out_b,         // 48/24 MHz output B
  output logic [5:0]                memory_clock_out,          // Memory fanout clocks
  output logic                      feedback_out,              // PLL feedback copy
  output logic                      osc_enable,                // Oscillator run
  output logic                      vco_enable                 // PLL stage run
);

  // Register state
  logic [scc_pkg::NCH-1:0]      enable_r;
  logic [scc_pkg::FIXSEL_W-1:0] fixsel_r;
  logic                         wr_pend_r;
  logic [7:0]                   addr_r;
  logic [31:0]                  rdata_nxt;
  logic                         access;

  // Derived control
  logic                         pci_stop_n;
  logic                         cpu_stop_n;
  logic                         cpu_src;
  logic                         fix_a_src;
  logic                         fix_b_src;
  logic                         pwr_run_r;
  scc_pkg::scc_status_s         status;

  // Per-channel source and run vectors
  logic [scc_pkg::NCH-1:0]      src_vec;
  logic [scc_pkg::NCH-1:0]      run_vec;
  logic [scc_pkg::NCH-1:0]      out_vec;

  // Zero-wait slave: every transfer completes in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp     = scc_pkg::HRESP_OKAY;
  assign access    = hsel & hready & (htrans == scc_pkg::HTRANS_NONSEQ);

  // Address phase capture for writes; hsize is not checked, words only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
    end else begin
      wr_pend_r <= access & hwrite;
      addr_r    <= haddr[scc_pkg::ADDR_LSB_W-1:0];
    end
  end

  // Output enable register, all on from reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_r <= scc_pkg::ENABLE_RST;
    end else if (wr_pend_r && addr_r == scc_pkg::OFF_ENABLE) begin
      enable_r <= hwdata[scc_pkg::NCH-1:0];
    end
  end

  // Fixed output rate selects, 1 picks 48 MHz
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fixsel_r <= scc_pkg::FIXSEL_RST;
    end else if (wr_pend_r && addr_r == scc_pkg::OFF_FIXSEL) begin
      fixsel_r <= hwdata[scc_pkg::FIXSEL_W-1:0];
    end
  end

  // Read mux; a write still in its data phase is forwarded so that a
  // read right behind it returns the new value
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (haddr[scc_pkg::ADDR_LSB_W-1:0])
      scc_pkg::OFF_ENABLE: begin
        if (wr_pend_r && addr_r == scc_pkg::OFF_ENABLE) begin
          rdata_nxt[scc_pkg::NCH-1:0] = hwdata[scc_pkg::NCH-1:0];
        end else begin
          rdata_nxt[scc_pkg::NCH-1:0] = enable_r;
        end
      end
      scc_pkg::OFF_FIXSEL: begin
        if (wr_pend_r && addr_r == scc_pkg::OFF_FIXSEL) begin
          rdata_nxt[scc_pkg::FIXSEL_W-1:0] = hwdata[scc_pkg::FIXSEL_W-1:0];
        end else begin
          rdata_nxt[scc_pkg::FIXSEL_W-1:0] = fixsel_r;
        end
      end
      scc_pkg::OFF_STATUS: begin
        rdata_nxt[scc_pkg::STATUS_W-1:0] = status;
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  // Read data registered at the address phase, stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (access && !hwrite) begin
      hrdata <= rdata_nxt;
    end
  end

  // Shared pins are stop inputs only in mode 0; otherwise stops are idle
  always_comb begin
    if (mode_select == scc_pkg::MODE_MEMORY) begin
      pci_stop_n = 1'b1;
      cpu_stop_n = 1'b1;
    end else begin
      pci_stop_n = memory_clock_extra_a_i;
      cpu_stop_n = memory_clock_extra_b_i;
    end
  end

  // Shared pins drive only in mode 1
  assign memory_clock_extra_a_oe = (mode_select == scc_pkg::MODE_MEMORY);
  assign memory_clock_extra_b_oe = (mode_select == scc_pkg::MODE_MEMORY);
  assign memory_clock_extra_a_o  = out_vec[scc_pkg::CH_MEMA];
  assign memory_clock_extra_b_o  = out_vec[scc_pkg::CH_MEMB];

  // Power-down stops oscillator and PLL; registered so the pins are clean
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_run_r <= 1'b0;
    end else begin
      pwr_run_r <= power_down_n;
    end
  end

  assign osc_enable = pwr_run_r;
  assign vco_enable = pwr_run_r;

  // Source selection; a speed change mid-cycle is not glitch-guarded,
  // the pin is expected to stay put while the outputs run
  assign cpu_src   = cpu_speed_select ? pll_src.cpu_100 : pll_src.cpu_66;
  assign fix_a_src = fixsel_r[scc_pkg::FIXSEL_A] ? pll_src.fix_48 : pll_src.fix_24;
  assign fix_b_src = fixsel_r[scc_pkg::FIXSEL_B] ? pll_src.fix_48 : pll_src.fix_24;

  // Status view of the block's live controls
  always_comb begin
    status.vco_run    = pwr_run_r;
    status.osc_run    = pwr_run_r;
    status.cpu_stop_n = cpu_stop_n;
    status.pci_stop_n = pci_stop_n;
    status.speed      = cpu_speed_select;
    status.mode       = mode_select;
  end

  // Channel sources and run conditions, assigned group by group
  always_comb begin
    src_vec = '0;
    run_vec = '0;
    for (int i = 0; i < scc_pkg::NCPU; i++) begin
      src_vec[scc_pkg::CH_CPU0+i] = cpu_src;
      run_vec[scc_pkg::CH_CPU0+i] = cpu_stop_n;
    end
    for (int i = 0; i < scc_pkg::NPCI; i++) begin
      src_vec[scc_pkg::CH_PCI0+i] = pll_src.pci;
      run_vec[scc_pkg::CH_PCI0+i] = pci_stop_n;
    end
    src_vec[scc_pkg::CH_PCIF] = pll_src.pci;
    run_vec[scc_pkg::CH_PCIF] = 1'b1;
    for (int i = 0; i < scc_pkg::NREF; i++) begin
      src_vec[scc_pkg::CH_REF0+i] = crystal_input;
      run_vec[scc_pkg::CH_REF0+i] = 1'b1;
    end
    src_vec[scc_pkg::CH_FIXA] = fix_a_src;
    run_vec[scc_pkg::CH_FIXA] = 1'b1;
    src_vec[scc_pkg::CH_FIXB] = fix_b_src;
    run_vec[scc_pkg::CH_FIXB] = 1'b1;
    for (int i = 0; i < scc_pkg::NMEM; i++) begin
      src_vec[scc_pkg::CH_MEM0+i] = buf_in;
      run_vec[scc_pkg::CH_MEM0+i] = 1'b1;
    end
    src_vec[scc_pkg::CH_MEMA] = buf_in;
    run_vec[scc_pkg::CH_MEMA] = (mode_select == scc_pkg::MODE_MEMORY);
    src_vec[scc_pkg::CH_MEMB] = buf_in;
    run_vec[scc_pkg::CH_MEMB] = (mode_select == scc_pkg::MODE_MEMORY);
    // Enable bit and power state apply to every channel
    run_vec = run_vec & enable_r & {scc_pkg::NCH{power_down_n}};
  end

  // One glitch-free gate per output channel
  genvar g;
  generate
    for (g = 0; g < scc_pkg::NCH; g++) begin : g_gate
      scc_clk_gate u_gate (
        .hclk    (hclk),
        .hresetn (hresetn),
        .src     (src_vec[g]),
        .run     (run_vec[g]),
        .clk_out (out_vec[g])
      );
    end
  endgenerate

  // Output pins taken from the gate bank
  assign cpu_clock_out          = out_vec[scc_pkg::CH_CPU0 +: scc_pkg::NCPU];
  assign pci_clock_out          = out_vec[scc_pkg::CH_PCI0 +: scc_pkg::NPCI];
  assign pci_clock_free_running = out_vec[scc_pkg::CH_PCIF];
  assign ref_clock_out          = out_vec[scc_pkg::CH_REF0 +: scc_pkg::NREF];
  assign fixed_clock_out_a      = out_vec[scc_pkg::CH_FIXA];
  assign fixed_clock_out_b      = out_vec[scc_pkg::CH_FIXB];
  assign memory_clock_out       = out_vec[scc_pkg::CH_MEM0 +: scc_pkg::NMEM];

  // Feedback copies the selected processor source, halted in power-down
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      feedback_out <= 1'b0;
    end else begin
      feedback_out <= cpu_src & power_down_n;
    end
  end

endmodule

// *** testbench/scc_checker.sv ***
// Checker for the clock output block: timing relations at the top ports.
// Assumes every clock source has a half period of at most four hclk cycles.
module scc_checker (
  input  wire logic              hclk,                     // Bus clock
  input  wire logic              hresetn,                  // Reset, active low
  input  wire logic              hreadyout,                // Slave ready
  input  wire logic              hresp,                    // Response
  input  wire logic              cpu_speed_select,         // Speed pin
  input  wire logic              power_down_n,             // Power-down pin
  input  wire logic              mode_select,              // Mode pin
  input  wire logic              crystal_input,            // Crystal level
  input  wire logic              buf_in,                   // Buffer input
  input  wire scc_pkg::scc_src_s pll_src,                  // Source levels
  input  wire logic              memory_clock_extra_a_i,   // Pin A level
  input  wire logic              memory_clock_extra_a_oe,  // Pin A enable
  input  wire logic              memory_clock_extra_b_i,   // Pin B level
  input  wire logic              memory_clock_extra_b_oe,  // Pin B enable
  input  wire logic [1:0]        cpu_clock_out,            // Processor clocks
  input  wire logic [5:0]        pci_clock_out,            // Stoppable bus clocks
  input  wire logic              pci_clock_free_running,   // Free bus clock
  input  wire logic [2:0]        ref_clock_out,            // Reference clocks
  input  wire logic              fixed_clock_out_a,        // Fixed output A
  input  wire logic              fixed_clock_out_b,        // Fixed output B
  input  wire logic [5:0]        memory_clock_out,         // Memory clocks
  input  wire logic              feedback_out,             // Feedback copy
  input  wire logic              osc_enable,               // Oscillator run
  input  wire logic              vco_enable                // PLL stage run
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Requests held for eight cycles always span a low source phase
  sequence s_pci_hold; (!mode_select && !memory_clock_extra_a_i) [*8]; endsequence
  sequence s_cpu_hold; (!mode_select && !memory_clock_extra_b_i) [*8]; endsequence
  sequence s_pd_hold; (!power_down_n) [*8]; endsequence
  a_bus_okay: assert property (hreadyout && hresp == scc_pkg::HRESP_OKAY)
    else $error("bus answer not ready or not okay");
  a_cpu_rate_sel: assert property (cpu_clock_out[0] |->
    $past(cpu_speed_select ? pll_src.cpu_100 : pll_src.cpu_66))
    else $error("processor clock high without selected source");
  a_pci_stop_low: assert property (s_pci_hold |-> pci_clock_out == 6'h00)
    else $error("bus clocks running while stopped");
  a_cpu_stop_low: assert property (s_cpu_hold |-> cpu_clock_out == 2'h0)
    else $error("processor clocks running while stopped");
  a_free_pci_src: assert property (pci_clock_free_running |-> $past(pll_src.pci))
    else $error("free bus clock not a copy of its source");
  a_osc_follow: assert property ($past(hresetn) |->
    osc_enable == $past(power_down_n) && vco_enable == $past(power_down_n))
    else $error("oscillator or PLL enable not following power-down");
  a_pdn_quiet: assert property (s_pd_hold |-> {cpu_clock_out, pci_clock_out,
    pci_clock_free_running, ref_clock_out, fixed_clock_out_a, fixed_clock_out_b,
    memory_clock_out, feedback_out} == 21'h000000)
    else $error("outputs running in power-down");
  a_shared_oe: assert property (memory_clock_extra_a_oe == mode_select
    && memory_clock_extra_b_oe == mode_select)
    else $error("shared pin enable differs from mode");
  a_mem_copy: assert property (memory_clock_out != 6'h00 |-> $past(buf_in))
    else $error("memory clock high without buffer input");
  a_ref_copy: assert property (ref_clock_out != 3'h0 |-> $past(crystal_input))
    else $error("reference clock high without crystal");
endmodule

bind scc_top scc_checker i_chk (.*);

// *** testbench/scc_src_model.sv ***
// Far side model: free-running source levels and the chipset stop drivers.
// Assumes hclk at 50 MHz; sources change right after each rising edge.
module scc_src_model (
  input  wire logic         hclk,        // Bus clock
  input  wire logic         pci_stop_n,  // Requested bus stop level
  input  wire logic         cpu_stop_n,  // Requested processor stop level
  input  wire logic         a_o,         // Pin A drive from block
  input  wire logic         a_oe,        // Pin A enable from block
  input  wire logic         b_o,         // Pin B drive from block
  input  wire logic         b_oe,        // Pin B enable from block
  output logic              a_i,         // Pin A wire level
  output logic              b_i,         // Pin B wire level
  output logic              crystal,     // Crystal level
  output logic              buf_lvl,     // Buffer input level
  output scc_pkg::scc_src_s src          // PLL source levels
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_r = 5'h00;
  // One counter for all sources; 24 is their common period
  always @(posedge hclk) cnt_r <= (cnt_r == 5'h17) ? 5'h00 : cnt_r + 5'h01;
  // Periods 6, 4, 8, 4, 8 cycles; all divide 48 so rise counts are exact
  assign src = '{cpu_66: (cnt_r % 6) < 3, cpu_100: cnt_r[1], pci: cnt_r[2],
                 fix_48: cnt_r[1], fix_24: cnt_r[2]};
  assign crystal = cnt_r[2];
  assign buf_lvl = (cnt_r % 6) >= 3;
  // Wire level: block drives in memory mode, chipset stop level otherwise
  assign a_i = a_oe ? a_o : pci_stop_n;
  assign b_i = b_oe ? b_o : cpu_stop_n;
endmodule

// *** testbench/tb.sv ***
// Top bench: drives the register port and pins, checks registers and clocks.
// Assumes the source model on the far side and the bound checker.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, v;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, crystal_input, buf_in, feedback_out, osc_enable, vco_enable;
  logic        cpu_speed_select = 1'b1, power_down_n = 1'b1, mode_select = 1'b1;
  logic        pci_stop_n = 1'b1, cpu_stop_n = 1'b1, rd_dp = 1'b0;
  logic        memory_clock_extra_a_i, memory_clock_extra_a_o, memory_clock_extra_a_oe;
  logic        memory_clock_extra_b_i, memory_clock_extra_b_o, memory_clock_extra_b_oe;
  logic        pci_clock_free_running, fixed_clock_out_a, fixed_clock_out_b;
  logic [1:0]  cpu_clock_out;
  logic [5:0]  pci_clock_out, memory_clock_out;
  logic [2:0]  ref_clock_out;
  logic [21:0] act;
  scc_pkg::scc_src_s pll_src;
  logic [31:0] exp_q[$];
  int          err_total = 0, total_checks = 0, seed = 32'h882d9b84;
  // Clock, single slave ready loop, activity vector in channel order
  always #10 hclk = ~hclk;
  assign hready = hreadyout;
  assign act = {memory_clock_extra_b_o, memory_clock_extra_a_o, memory_clock_out,
                fixed_clock_out_b, fixed_clock_out_a, ref_clock_out,
                pci_clock_free_running, pci_clock_out, cpu_clock_out};
  scc_top i_dut (.*);
  scc_src_model i_src (.hclk(hclk), .pci_stop_n(pci_stop_n), .cpu_stop_n(cpu_stop_n),
    .a_o(memory_clock_extra_a_o), .a_oe(memory_clock_extra_a_oe),
    .b_o(memory_clock_extra_b_o), .b_oe(memory_clock_extra_b_oe),
    .a_i(memory_clock_extra_a_i), .b_i(memory_clock_extra_b_i),
    .crystal(crystal_input), .buf_lvl(buf_in), .src(pll_src));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One single transfer; a read notes its expected data for the monitor
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= scc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) exp_q.push_back(d);
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask
  // Read data stands after the data phase edge, so look one edge later
  always @(posedge hclk) begin
    if (rd_dp) chk("hrdata", exp_q.pop_front(), hrdata);
    rd_dp <= hsel && hready && htrans == scc_pkg::HTRANS_NONSEQ && !hwrite;
  end
  // Which outputs went high at all; a stopped clock must sit low
  task automatic watch(input logic [21:0] e);
    logic [21:0] seen;
    seen = '0;
    repeat (12) @(posedge hclk);
    repeat (24) begin
      @(posedge hclk);
      seen |= act;
    end
    chk("activity", {10'h000, e}, {10'h000, seen});
  endtask
  // Rising edges in 48 cycles: processor, fixed A, fixed B, free bus clock
  task automatic rates(input logic [31:0] ec, ea, eb, ef);
    logic [3:0]  p;
    logic [31:0] n [4];
    n = '{default: 32'h0};
    repeat (8) @(posedge hclk);
    p = {pci_clock_free_running, fixed_clock_out_b, fixed_clock_out_a, cpu_clock_out[0]};
    repeat (48) begin
      @(posedge hclk);
      for (int i = 0; i < 4; i++) n[i] += 32'(act_r(i) & ~p[i]);
      p = {pci_clock_free_running, fixed_clock_out_b, fixed_clock_out_a, cpu_clock_out[0]};
    end
    chk("cpu rate", ec, n[0]);
    chk("fixed a rate", ea, n[1]);
    chk("fixed b rate", eb, n[2]);
    chk("free bus rate", ef, n[3]);
  endtask
  function automatic logic act_r(input int i);
    logic [3:0] t;
    t = {pci_clock_free_running, fixed_clock_out_b, fixed_clock_out_a, cpu_clock_out[0]};
    return t[i];
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog far beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    err_total++;
    close_out();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, scc_pkg::OFF_ENABLE, {10'h000, scc_pkg::ENABLE_RST});
    bus(1'b0, scc_pkg::OFF_FIXSEL, 32'h00000003);
    bus(1'b1, scc_pkg::OFF_STATUS, 32'h00000000);
    bus(1'b1, 8'h0c, 32'hffffffff);
    bus(1'b0, scc_pkg::OFF_STATUS, 32'h0000003f);
    bus(1'b0, 8'h0c, 32'h00000000);
    watch(22'h3fffff);
    rates(32'd12, 32'd12, 32'd12, 32'd6);
    repeat (2) begin
      v = $random(seed) & 32'h003fffff;
      bus(1'b1, scc_pkg::OFF_ENABLE, v);
      bus(1'b0, scc_pkg::OFF_ENABLE, v);
      watch(v[21:0]);
    end
    bus(1'b1, scc_pkg::OFF_ENABLE, 32'h003fffff);
    bus(1'b1, scc_pkg::OFF_FIXSEL, 32'h00000001);
    cpu_speed_select <= 1'b0;
    rates(32'd8, 32'd12, 32'd6, 32'd6);
    cpu_speed_select <= 1'b1;
    bus(1'b1, scc_pkg::OFF_FIXSEL, 32'h00000002);
    rates(32'd12, 32'd6, 32'd12, 32'd6);
    mode_select <= 1'b0;
    pci_stop_n <= 1'b0;
    watch(22'h0fff03);
    cpu_stop_n <= 1'b0;
    watch(22'h0fff00);
    bus(1'b0, scc_pkg::OFF_STATUS, 32'h00000032);
    pci_stop_n <= 1'b1;
    cpu_stop_n <= 1'b1;
    mode_select <= 1'b1;
    power_down_n <= 1'b0;
    watch(22'h000000);
    bus(1'b0, scc_pkg::OFF_STATUS, 32'h0000000f);
    power_down_n <= 1'b1;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, scc_pkg::OFF_FIXSEL, 32'h00000003);
    watch(22'h3fffff);
    close_out();
  end
endmodule
